// File: hdl/olw_top.sv
// over-limit and critical comparator watchdog with its register set
`timescale 1ns/1ps
`include "olw_defs.svh"

module olw_top
  import olw_pkg::*;
#(
  parameter int FILT_STEP_CYC = `OLW_FILT_STEP_CYC,
  parameter int WARN_STEP_CYC = `OLW_WARN_STEP_CYC
)
(
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_ce,
  input  wire logic [`OLW_ADDR_W-1:0] i_reg_addr,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [`OLW_DATA_W-1:0] i_reg_wdata,
  output logic      [`OLW_DATA_W-1:0] o_reg_rdata,
  input  wire logic [15:0]            i_power_result,
  input  wire logic [15:0]            i_bus_result,
  input  wire logic                   i_result_valid,
  input  wire logic signed [9:0]      i_shunt_mv,
  input  wire logic                   i_overlimit_out_enable,
  input  wire logic                   i_watt_flag_clear,
  input  wire logic                   i_bus_high_flag_clear,
  input  wire logic                   i_bus_low_flag_clear,
  input  wire logic                   i_critical_flag_clear,
  output logic                        o_watt_flag,
  output logic                        o_bus_high_trip_flag,
  output logic                        o_bus_low_trip_flag,
  output logic                        o_critical_flag,
  output logic                        o_overlimit_pin,
  output logic                        o_critical_pin_o,
  output logic                        o_critical_pin_oe,
  input  wire logic                   i_aux_pin,
  output logic                        o_aux_pin_o,
  output logic                        o_aux_pin_oe,
  output logic [3:0]                  o_warning_delay,
  output logic [31:0]                 o_warning_delay_cycles
);

  // register fields
  logic [15:0]     watt_ceiling_r;
  logic [12:0]     bus_high_cutoff_r;
  logic            overlimit_flip_r;
  logic            overlimit_latch_sel_r;
  logic [12:0]     bus_low_cutoff_r;
  logic [7:0]      critical_threshold_r;
  olw_aux_mode_t   aux_pin_mode_r;
  logic            critical_polarity_r;
  logic [2:0]      critical_hysteresis_r;
  logic            critical_latch_r;
  logic [7:0]      critical_neg_threshold_r;
  logic [3:0]      comparator_filter_r;
  logic [3:0]      warning_delay_r;

  // measurement capture and comparison
  logic [15:0]     power_hold_r;
  logic [12:0]     bus_hold_r;
  logic            have_result_r;
  logic            watt_over;
  logic            bus_high_over;
  logic            bus_low_under;
  logic            overlimit_live;
  logic            overlimit_active;

  // critical comparator
  olw_crit_state_t crit_state_r;
  olw_crit_state_t crit_state_nxt;
  logic signed [10:0] shunt_s;
  logic signed [10:0] pos_lim;
  logic signed [10:0] neg_lim;
  logic signed [10:0] hyst_mv;
  logic            crit_filt;
  logic            crit_active;
  logic            crit_level;

  // aux pin synchroniser
  logic            aux_s1_r;
  logic            aux_s2_r;
  logic            aux_s3_r;
  logic            aux_pin_level_r;

  logic            wr_en;
  logic [`OLW_DATA_W-1:0] rdata_nxt;

  function automatic logic signed [10:0] olw_mv(input logic [7:0] code);
    olw_mv = signed'({3'h0, code});
  endfunction

  function automatic logic signed [10:0] olw_hyst_mv(input logic [2:0] code);
    olw_hyst_mv = signed'(11'(32'(code) * `OLW_HYST_STEP_MV));
  endfunction

  assign wr_en = i_ce & i_reg_wr;

  // register writes, one block per register
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      watt_ceiling_r <= `OLW_RST_WATT_CEILING;
    else if (wr_en && i_reg_addr == `OLW_OFS_WATT_CEILING)
      watt_ceiling_r <= i_reg_wdata;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      bus_high_cutoff_r     <= 13'(`OLW_RST_BUS_HIGH >> `OLW_CUTOFF_LSB);
      overlimit_flip_r      <= 1'b0;
      overlimit_latch_sel_r <= 1'b0;
    end
    else if (wr_en && i_reg_addr == `OLW_OFS_BUS_HIGH)
    begin
      bus_high_cutoff_r     <= i_reg_wdata[`OLW_CUTOFF_MSB:`OLW_CUTOFF_LSB];
      overlimit_flip_r      <= i_reg_wdata[`OLW_OL_FLIP_BIT];
      overlimit_latch_sel_r <= i_reg_wdata[`OLW_OL_LATCH_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      bus_low_cutoff_r <= 13'(`OLW_RST_BUS_LOW >> `OLW_CUTOFF_LSB);
    else if (wr_en && i_reg_addr == `OLW_OFS_BUS_LOW)
      bus_low_cutoff_r <= i_reg_wdata[`OLW_CUTOFF_MSB:`OLW_CUTOFF_LSB];
  end

  // readback bit 7 is not writable
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      critical_threshold_r  <= 8'h00;
      aux_pin_mode_r        <= OLW_AUX_HIZ_A;
      critical_polarity_r   <= 1'b0;
      critical_hysteresis_r <= 3'h0;
      critical_latch_r      <= 1'b0;
    end
    else if (wr_en && i_reg_addr == `OLW_OFS_CRIT_POS)
    begin
      critical_threshold_r  <= i_reg_wdata[`OLW_CRIT_THR_MSB:`OLW_CRIT_THR_LSB];
      aux_pin_mode_r        <= olw_aux_mode_t'(i_reg_wdata[`OLW_AUX_MODE_MSB:`OLW_AUX_MODE_LSB]);
      critical_polarity_r   <= i_reg_wdata[`OLW_CRIT_POL_BIT];
      critical_hysteresis_r <= i_reg_wdata[`OLW_CRIT_HYST_MSB:`OLW_CRIT_HYST_LSB];
      critical_latch_r      <= i_reg_wdata[`OLW_CRIT_LATCH_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      critical_neg_threshold_r <= 8'h00;
      comparator_filter_r      <= 4'h0;
      warning_delay_r          <= 4'h0;
    end
    else if (wr_en && i_reg_addr == `OLW_OFS_CRIT_NEG)
    begin
      critical_neg_threshold_r <= i_reg_wdata[`OLW_CRIT_THR_MSB:`OLW_CRIT_THR_LSB];
      comparator_filter_r      <= i_reg_wdata[`OLW_FILTER_MSB:`OLW_FILTER_LSB];
      warning_delay_r          <= i_reg_wdata[`OLW_WARN_DLY_MSB:`OLW_WARN_DLY_LSB];
    end
  end

  // read mux; unmapped offsets and reserved bits read zero
  always_comb
  begin
    rdata_nxt = '0;
    case (i_reg_addr)
      `OLW_OFS_WATT_CEILING:
        rdata_nxt = watt_ceiling_r;
      `OLW_OFS_BUS_HIGH:
        rdata_nxt = {bus_high_cutoff_r, 1'b0, overlimit_flip_r, overlimit_latch_sel_r};
      `OLW_OFS_BUS_LOW:
        rdata_nxt = {bus_low_cutoff_r, 3'h0};
      `OLW_OFS_CRIT_POS:
        rdata_nxt = {critical_threshold_r, aux_pin_level_r, aux_pin_mode_r,
                     critical_polarity_r, critical_hysteresis_r, critical_latch_r};
      `OLW_OFS_CRIT_NEG:
        rdata_nxt = {critical_neg_threshold_r, comparator_filter_r, warning_delay_r};
      default:
        rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_reg_rdata <= '0;
    else if (i_ce && i_reg_rd)
      o_reg_rdata <= rdata_nxt;
  end

  // latest results are held so a transparent pin follows the last comparison
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      power_hold_r  <= 16'h0000;
      bus_hold_r    <= 13'h0000;
      have_result_r <= 1'b0;
    end
    else if (i_ce && i_result_valid)
    begin
      power_hold_r  <= i_power_result;
      bus_hold_r    <= i_bus_result[`OLW_CUTOFF_MSB:`OLW_CUTOFF_LSB];
      have_result_r <= 1'b1;
    end
  end

  assign watt_over     = have_result_r & (power_hold_r > watt_ceiling_r);
  assign bus_high_over = have_result_r & (bus_hold_r > bus_high_cutoff_r);
  assign bus_low_under = have_result_r & (bus_hold_r < bus_low_cutoff_r);

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_watt_flag <= 1'b0;
    else if (i_ce)
      o_watt_flag <= watt_over | (o_watt_flag & ~i_watt_flag_clear);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_bus_high_trip_flag <= 1'b0;
    else if (i_ce)
      o_bus_high_trip_flag <= bus_high_over | (o_bus_high_trip_flag & ~i_bus_high_flag_clear);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_bus_low_trip_flag <= 1'b0;
    else if (i_ce)
      o_bus_low_trip_flag <= bus_low_under | (o_bus_low_trip_flag & ~i_bus_low_flag_clear);
  end

  assign overlimit_live = watt_over | bus_high_over | bus_low_under;

  // latched mode holds on the flags, so only a host clear or a low i_overlimit_out_enable releases the pin
  always_comb
  begin
    if (overlimit_latch_sel_r)
      overlimit_active = o_watt_flag | o_bus_high_trip_flag | o_bus_low_trip_flag;
    else
      overlimit_active = overlimit_live;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_overlimit_pin <= 1'b1;
    else if (i_ce)
      o_overlimit_pin <= (i_overlimit_out_enable & overlimit_active) ? overlimit_flip_r : ~overlimit_flip_r;
  end

  // critical window comparator with hysteresis on release
  assign shunt_s = {i_shunt_mv[9], i_shunt_mv};
  assign pos_lim = olw_mv(critical_threshold_r);
  assign neg_lim = 11'sd0 - olw_mv(critical_neg_threshold_r);
  assign hyst_mv = olw_hyst_mv(critical_hysteresis_r);

  always_comb
  begin
    crit_state_nxt = crit_state_r;
    case (crit_state_r)
      OLW_CRIT_CLEAR:
        if (shunt_s > pos_lim || shunt_s < neg_lim)
          crit_state_nxt = OLW_CRIT_TRIP;
      OLW_CRIT_TRIP:
        if (shunt_s <= pos_lim - hyst_mv && shunt_s >= neg_lim + hyst_mv)
          crit_state_nxt = OLW_CRIT_CLEAR;
      default:
        crit_state_nxt = OLW_CRIT_CLEAR;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      crit_state_r <= OLW_CRIT_CLEAR;
    else if (i_ce)
      crit_state_r <= crit_state_nxt;
  end

  olw_filter #(
    .STEP_CYC (FILT_STEP_CYC)
  ) u_filter (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_code   (comparator_filter_r),
    .i_raw    (crit_state_r == OLW_CRIT_TRIP),
    .o_filt   (crit_filt)
  );

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_critical_flag <= 1'b0;
    else if (i_ce)
      o_critical_flag <= crit_filt | (o_critical_flag & ~i_critical_flag_clear);
  end

  assign crit_active = critical_latch_r ? o_critical_flag : crit_filt;
  assign crit_level  = crit_active ? critical_polarity_r : ~critical_polarity_r;

  // open drain: only ever pulls low, a high level is left to the pull-up
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_critical_pin_oe <= 1'b0;
    else if (i_ce)
      o_critical_pin_oe <= ~crit_level;
  end

  assign o_critical_pin_o = 1'b0;

  // aux pin: three stages, a change counts once stages two and three agree
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      aux_s1_r <= 1'b0;
      aux_s2_r <= 1'b0;
      aux_s3_r <= 1'b0;
    end
    else if (i_ce)
    begin
      aux_s1_r <= i_aux_pin;
      aux_s2_r <= aux_s1_r;
      aux_s3_r <= aux_s2_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      aux_pin_level_r <= 1'b0;
    else if (i_ce && aux_s2_r == aux_s3_r)
      aux_pin_level_r <= aux_s3_r;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_aux_pin_oe <= 1'b0;
      o_aux_pin_o  <= 1'b0;
    end
    else if (i_ce)
    begin
      o_aux_pin_oe <= (aux_pin_mode_r == OLW_AUX_LOW) || (aux_pin_mode_r == OLW_AUX_HIGH);
      o_aux_pin_o  <= (aux_pin_mode_r == OLW_AUX_HIGH);
    end
  end

  // the warning pin lives elsewhere; it is handed the code and its length in cycles
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_warning_delay        <= 4'h0;
      o_warning_delay_cycles <= 32'h0000_0000;
    end
    else if (i_ce)
    begin
      o_warning_delay        <= warning_delay_r;
      o_warning_delay_cycles <= 32'(32'(warning_delay_r) * WARN_STEP_CYC);
    end
  end

endmodule

// File: hdl/olw_defs.svh
// register offsets, field positions, reset values and timing constants of the over-limit watchdog
`ifndef OLW_DEFS_SVH
`define OLW_DEFS_SVH

`define OLW_ADDR_W              8
`define OLW_DATA_W              16

`define OLW_OFS_WATT_CEILING    8'h11
`define OLW_OFS_BUS_HIGH        8'h12
`define OLW_OFS_BUS_LOW         8'h13
`define OLW_OFS_CRIT_POS        8'h14
`define OLW_OFS_CRIT_NEG        8'h15

`define OLW_CUTOFF_MSB          15
`define OLW_CUTOFF_LSB          3
`define OLW_OL_FLIP_BIT         1
`define OLW_OL_LATCH_BIT        0

`define OLW_CRIT_THR_MSB        15
`define OLW_CRIT_THR_LSB        8
`define OLW_AUX_LEVEL_BIT       7
`define OLW_AUX_MODE_MSB        6
`define OLW_AUX_MODE_LSB        5
`define OLW_CRIT_POL_BIT        4
`define OLW_CRIT_HYST_MSB       3
`define OLW_CRIT_HYST_LSB       1
`define OLW_CRIT_LATCH_BIT      0
`define OLW_FILTER_MSB          7
`define OLW_FILTER_LSB          4
`define OLW_WARN_DLY_MSB        3
`define OLW_WARN_DLY_LSB        0

`define OLW_RST_WATT_CEILING    16'h0000
`define OLW_RST_BUS_HIGH        16'h0000
`define OLW_RST_BUS_LOW         16'h0000
`define OLW_RST_CRIT_POS        16'h0000
`define OLW_RST_CRIT_NEG        16'h0000

// one hysteresis step in millivolts
`define OLW_HYST_STEP_MV        2

`define OLW_CLK_PERIOD_NS       20
// filter step 0.064 ms, a least hold time: rounded up
`define OLW_FILT_STEP_NS        64000
`define OLW_FILT_STEP_CYC       ((`OLW_FILT_STEP_NS + `OLW_CLK_PERIOD_NS - 1) / `OLW_CLK_PERIOD_NS)
// warning delay step 0.1 s
`define OLW_WARN_STEP_NS        100000000
`define OLW_WARN_STEP_CYC       (`OLW_WARN_STEP_NS / `OLW_CLK_PERIOD_NS)

`endif

// File: hdl/olw_pkg.sv
// types shared by the over-limit watchdog modules
package olw_pkg;

  typedef enum logic [1:0]
  {
    OLW_AUX_HIZ_A = 2'h0,
    OLW_AUX_HIZ_B = 2'h1,
    OLW_AUX_LOW   = 2'h2,
    OLW_AUX_HIGH  = 2'h3
  } olw_aux_mode_t;

  typedef enum logic
  {
    OLW_CRIT_CLEAR = 1'b0,
    OLW_CRIT_TRIP  = 1'b1
  } olw_crit_state_t;

endpackage

// File: hdl/olw_filter.sv
// hold-time filter for the critical comparator result
`timescale 1ns/1ps
`include "olw_defs.svh"

module olw_filter
  import olw_pkg::*;
#(
  parameter int STEP_CYC = `OLW_FILT_STEP_CYC,
  parameter int CNT_W    = 20
)
(
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_ce,
  input  wire logic [3:0] i_code,
  input  wire logic       i_raw,
  output logic            o_filt
);

  logic [CNT_W-1:0] hold_cnt_r;
  logic [CNT_W-1:0] hold_lim;

  // hold needed is code steps; code zero passes after one register stage
  assign hold_lim = CNT_W'(32'(i_code) * STEP_CYC);

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      hold_cnt_r <= '0;
      o_filt     <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_raw == o_filt)
      begin
        // any return to the old value restarts the hold
        hold_cnt_r <= '0;
      end
      else if (hold_cnt_r + CNT_W'(1) >= hold_lim)
      begin
        o_filt     <= i_raw;
        hold_cnt_r <= '0;
      end
      else
      begin
        hold_cnt_r <= hold_cnt_r + CNT_W'(1);
      end
    end
  end

endmodule

// File: verif/olw_monitor.sv
// port-level assertion checker for the over-limit watchdog
`timescale 1ns/1ps
module olw_monitor
#(
  parameter int WARN_STEP_CYC = 10
)
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic [15:0] o_reg_rdata,
  input  wire logic        i_watt_flag_clear,
  input  wire logic        i_critical_flag_clear,
  input  wire logic        o_watt_flag,
  input  wire logic        o_critical_flag,
  input  wire logic        o_critical_pin_o,
  input  wire logic        o_aux_pin_o,
  input  wire logic        o_aux_pin_oe,
  input  wire logic [3:0]  o_warning_delay,
  input  wire logic [31:0] o_warning_delay_cycles
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  logic wr14;
  assign wr14 = i_ce && i_reg_wr && (i_reg_addr == 8'h14);

  sequence s_wr14;
    i_ce && i_reg_wr && (i_reg_addr == 8'h14);
  endsequence
  sequence s_wr15;
    i_ce && i_reg_wr && (i_reg_addr == 8'h15);
  endsequence

  AST_AUX_MODE: assert property (s_wr14 ##1 i_ce |=> o_aux_pin_oe == $past(i_reg_wdata[6], 2) &&
    (!o_aux_pin_oe || o_aux_pin_o == $past(i_reg_wdata[5], 2))) else $error("aux pin mode not applied");
  AST_AUX_HOLD: assert property ($changed(o_aux_pin_oe) |-> $past(wr14) || $past(wr14, 2))
    else $error("aux pin enable moved without a write");
  AST_WDLY_WR: assert property (s_wr15 ##1 i_ce |=> o_warning_delay == $past(i_reg_wdata[3:0], 2))
    else $error("warning delay code not applied");
  AST_WDLY_CYC: assert property ($stable(o_warning_delay) |->
    o_warning_delay_cycles == WARN_STEP_CYC * o_warning_delay) else $error("warning delay cycles wrong");
  AST_CRIT_OD: assert property (o_critical_pin_o == 1'b0)
    else $error("critical pin drives high");
  AST_WATT_STICKY: assert property (o_watt_flag && !i_watt_flag_clear |=> o_watt_flag)
    else $error("power flag dropped without clear");
  AST_WATT_CLEAR: assert property ($fell(o_watt_flag) |-> $past(i_watt_flag_clear && i_ce))
    else $error("power flag fell without clear");
  AST_CRIT_CLEAR: assert property ($fell(o_critical_flag) |-> $past(i_critical_flag_clear && i_ce))
    else $error("critical flag fell without clear");
  AST_RES_BITS: assert property (i_ce && i_reg_rd && i_reg_addr == 8'h13 |=> o_reg_rdata[2:0] == 3'h0)
    else $error("reserved bits read nonzero");
endmodule

bind olw_top olw_monitor #(.WARN_STEP_CYC(WARN_STEP_CYC)) u_mon (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .i_watt_flag_clear(i_watt_flag_clear), .i_critical_flag_clear(i_critical_flag_clear),
  .o_watt_flag(o_watt_flag), .o_critical_flag(o_critical_flag), .o_critical_pin_o(o_critical_pin_o),
  .o_aux_pin_o(o_aux_pin_o), .o_aux_pin_oe(o_aux_pin_oe), .o_warning_delay(o_warning_delay),
  .o_warning_delay_cycles(o_warning_delay_cycles));

// File: verif/olw_pins_model.sv
// board-side pin model: pulled-up aux wire with an outside driver, open-drain critical wire
`timescale 1ns/1ps
module olw_pins_model
(
  input  wire logic i_aux_o,
  input  wire logic i_aux_oe,
  input  wire logic i_ext_en,
  input  wire logic i_ext_val,
  input  wire logic i_crit_oe,
  output logic      o_aux_wire,
  output logic      o_crit_wire
);
  // released wire settles at the pull-up level unless the outside driver holds the aux wire
  assign o_aux_wire  = i_aux_oe ? i_aux_o : (i_ext_en ? i_ext_val : 1'b1);
  assign o_crit_wire = i_crit_oe ? 1'b0 : 1'b1;
endmodule

// File: verif/tb.sv
// self-checking bench for the over-limit watchdog
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL %s exp=%h got=%h", n, e, g); end end
module tb;
  logic              i_clk = 1'b0;
  logic              i_resetn = 1'b0;
  logic              ce = 1'b1;
  logic [7:0]        addr = 8'h00;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [15:0]       wdata = 16'h0000;
  logic [15:0]       pwr = 16'h0000;
  logic [15:0]       bus = 16'h0000;
  logic              vld = 1'b0;
  logic signed [9:0] shunt = 10'sh000;
  logic              ol_en = 1'b1;
  logic [3:0]        clr = 4'h0;
  logic              ext_en = 1'b0;
  logic              ext_val = 1'b0;
  logic [15:0]       rdata;
  logic              f_watt, f_bhi, f_blo, f_crit, ol_pin, crit_o, crit_oe, aux_o, aux_oe, aux_wire, crit_wire;
  logic [3:0]        wdly;
  logic [31:0]       wdly_cyc;
  int                err_total = 0;
  int                n_compared = 0;

  // short counts keep filter and delay steps visible in a short run
  olw_top #(.FILT_STEP_CYC(4), .WARN_STEP_CYC(10)) uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_power_result(pwr), .i_bus_result(bus), .i_result_valid(vld), .i_shunt_mv(shunt),
    .i_overlimit_out_enable(ol_en), .i_watt_flag_clear(clr[0]), .i_bus_high_flag_clear(clr[1]),
    .i_bus_low_flag_clear(clr[2]), .i_critical_flag_clear(clr[3]), .o_watt_flag(f_watt),
    .o_bus_high_trip_flag(f_bhi), .o_bus_low_trip_flag(f_blo), .o_critical_flag(f_crit),
    .o_overlimit_pin(ol_pin), .o_critical_pin_o(crit_o), .o_critical_pin_oe(crit_oe), .i_aux_pin(aux_wire),
    .o_aux_pin_o(aux_o), .o_aux_pin_oe(aux_oe), .o_warning_delay(wdly), .o_warning_delay_cycles(wdly_cyc));

  olw_pins_model u_pins (.i_aux_o(aux_o), .i_aux_oe(aux_oe), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .i_crit_oe(crit_oe), .o_aux_wire(aux_wire), .o_crit_wire(crit_wire));

  always #10 i_clk = ~i_clk;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_clk);
    wr    <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] e);
    @(posedge i_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_clk);
    rd   <= 1'b0;
    @(negedge i_clk);
    `CHK(n, e, rdata)
  endtask

  // results captured at the edge after this call's first edge
  task automatic res(input logic [15:0] p, input logic [15:0] b);
    @(posedge i_clk);
    pwr <= p;
    bus <= b;
    vld <= 1'b1;
    @(posedge i_clk);
    vld <= 1'b0;
    tick(2);
  endtask

  task automatic clear(input logic [3:0] m);
    @(posedge i_clk);
    clr <= m;
    @(posedge i_clk);
    clr <= 4'h0;
    tick(1);
  endtask

  task automatic sh(input logic signed [9:0] v, input int n);
    @(posedge i_clk);
    shunt <= v;
    tick(n);
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    $display("FAIL timeout");
    end_sim();
  end

  initial
  begin
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    tick(6);
    `CHK("ol_pin", 1'b1, ol_pin)
    `CHK("crit_wire", 1'b1, crit_wire)
    rchk("ceiling", 8'h11, 16'h0000);
    rchk("bus_high", 8'h12, 16'h0000);
    rchk("bus_low", 8'h13, 16'h0000);
    rchk("crit_pos", 8'h14, 16'h0080);
    rchk("crit_neg", 8'h15, 16'h0000);
    rchk("unmapped", 8'h16, 16'h0000);
    $display("test reset done");
    wreg(8'h12, 16'hFFFF);
    rchk("bus_high", 8'h12, 16'hFFFB);
    wreg(8'h13, 16'hFFFF);
    rchk("bus_low", 8'h13, 16'hFFF8);
    wreg(8'h14, 16'hFF7F);
    tick(6);
    rchk("crit_pos", 8'h14, 16'hFFFF);
    wreg(8'h14, 16'h0040);
    tick(6);
    rchk("crit_pos", 8'h14, 16'h0040);
    @(posedge i_clk);
    ext_en <= 1'b1;
    wreg(8'h14, 16'h0020);
    tick(6);
    `CHK("aux_oe", 1'b0, aux_oe)
    rchk("crit_pos", 8'h14, 16'h0020);
    @(posedge i_clk);
    ext_val <= 1'b1;
    tick(6);
    rchk("crit_pos", 8'h14, 16'h00A0);
    @(posedge i_clk);
    ce <= 1'b0;
    wreg(8'h15, 16'h1234);
    @(posedge i_clk);
    ce <= 1'b1;
    rchk("crit_neg", 8'h15, 16'h0000);
    wreg(8'h15, 16'h000F);
    tick(2);
    `CHK("wdly", 4'hF, wdly)
    `CHK("wdly_cyc", 32'h00000096, wdly_cyc)
    $display("test registers done");
    wreg(8'h11, 16'h1000);
    wreg(8'h12, 16'hFFF8);
    wreg(8'h13, 16'h0000);
    res(16'h1000, 16'h8000);
    `CHK("watt_flag", 1'b0, f_watt)
    res(16'h1001, 16'h8000);
    `CHK("watt_flag", 1'b1, f_watt)
    `CHK("ol_pin", 1'b0, ol_pin)
    res(16'h0FFF, 16'h8000);
    `CHK("ol_pin", 1'b1, ol_pin)
    clear(4'h1);
    `CHK("watt_flag", 1'b0, f_watt)
    @(posedge i_clk);
    ol_en <= 1'b0;
    res(16'h1001, 16'h8000);
    `CHK("watt_flag", 1'b1, f_watt)
    `CHK("ol_pin", 1'b1, ol_pin)
    res(16'h0FFF, 16'h8000);
    clear(4'h1);
    @(posedge i_clk);
    ol_en <= 1'b1;
    wreg(8'h12, 16'hFFFB);
    res(16'h1001, 16'h8000);
    `CHK("ol_pin", 1'b1, ol_pin)
    res(16'h0FFF, 16'h8000);
    `CHK("ol_pin", 1'b1, ol_pin)
    clear(4'h1);
    `CHK("ol_pin", 1'b0, ol_pin)
    wreg(8'h12, 16'h8000);
    wreg(8'h13, 16'h4000);
    res(16'h0000, 16'h8007);
    `CHK("bus_high_flag", 1'b0, f_bhi)
    res(16'h0000, 16'h8008);
    `CHK("bus_high_flag", 1'b1, f_bhi)
    `CHK("ol_pin", 1'b0, ol_pin)
    res(16'h0000, 16'h3FF8);
    `CHK("bus_low_flag", 1'b1, f_blo)
    res(16'h0000, 16'h4000);
    `CHK("ol_pin", 1'b1, ol_pin)
    clear(4'h6);
    `CHK("bus_low_flag", 1'b0, f_blo)
    $display("test over-limit done");
    wreg(8'h14, 16'h0A00);
    wreg(8'h15, 16'h0500);
    sh(10'sh00A, 4);
    `CHK("crit_wire", 1'b1, crit_wire)
    sh(10'sh00B, 4);
    `CHK("crit_wire", 1'b0, crit_wire)
    `CHK("crit_flag", 1'b1, f_crit)
    sh(-10'sh005, 4);
    `CHK("crit_wire", 1'b1, crit_wire)
    sh(-10'sh006, 4);
    `CHK("crit_wire", 1'b0, crit_wire)
    wreg(8'h14, 16'h0A02);
    sh(10'sh00B, 4);
    sh(10'sh009, 4);
    `CHK("crit_wire", 1'b0, crit_wire)
    sh(10'sh008, 4);
    `CHK("crit_wire", 1'b1, crit_wire)
    wreg(8'h14, 16'h0A10);
    tick(2);
    `CHK("crit_wire", 1'b0, crit_wire)
    sh(10'sh00B, 4);
    `CHK("crit_wire", 1'b1, crit_wire)
    sh(10'sh000, 4);
    clear(4'h8);
    wreg(8'h14, 16'h0A01);
    sh(10'sh00B, 4);
    sh(10'sh000, 4);
    `CHK("crit_wire", 1'b0, crit_wire)
    clear(4'h8);
    tick(2);
    `CHK("crit_wire", 1'b1, crit_wire)
    wreg(8'h14, 16'h0A00);
    wreg(8'h15, 16'h0520);
    rchk("crit_neg", 8'h15, 16'h0520);
    sh(10'sh00B, 6);
    `CHK("crit_wire", 1'b1, crit_wire)
    tick(6);
    `CHK("crit_wire", 1'b0, crit_wire)
    $display("test critical done");
    end_sim();
  end
endmodule
